// >>> design/stic_defines.svh
`ifndef STIC_DEFINES_SVH
`define STIC_DEFINES_SVH

// Register bus geometry
`define STIC_ADDR_W 4
`define STIC_DATA_W 32

// Register offsets (word index on the plain port)
`define STIC_REG_IGMAX 4'h0
`define STIC_REG_IGPCT 4'h1
`define STIC_REG_INPOS 4'h2
`define STIC_REG_RES 4'h3
`define STIC_REG_MOTOR 4'h4
`define STIC_REG_DBAND 4'h5
`define STIC_REG_SCALE 4'h6
`define STIC_REG_IGAIN 4'h7
`define STIC_REG_DIST 4'h8
`define STIC_REG_TARGET 4'h9
`define STIC_REG_STATUS 4'hA

// Field widths
`define STIC_IGMAX_W 15
`define STIC_IGPCT_W 7
`define STIC_INPOS_W 15
`define STIC_RES_W 15
`define STIC_MOTOR_W 2
`define STIC_DBAND_W 28
`define STIC_IGAIN_W 22
`define STIC_SCALE_W 32
`define STIC_PROD_W 64

// Reset values and limits
`define STIC_IGMAX_RST 15'h2328
`define STIC_IGPCT_RST 7'h32
`define STIC_IGPCT_MAX 7'h63
`define STIC_INPOS_RST 15'h0002
`define STIC_INPOS_MIN 15'h0001
`define STIC_RES_RST 15'h1388
`define STIC_RES_MIN 15'h00C8
`define STIC_RES_MAX 15'h6400
`define STIC_MOTOR_RST 2'h0
`define STIC_DBAND_RST 28'h0000000
`define STIC_DBAND_MAX 28'hA000000
`define STIC_SCALE_RST 32'h00028F5C

// Scale arithmetic: resolver counts per rev times 2^16
`define STIC_DIVIDEND 32'h32000000
`define STIC_FRAC_LSB 16
`define STIC_DIV_STEPS 6'h20

// Status bit positions
`define STIC_ST_INPOS 0
`define STIC_ST_AMP 1
`define STIC_ST_BUSY 2
`define STIC_ST_REJECT 3

// Test interval timing
`define STIC_TICK_MS 10
`define STIC_CLK_KHZ 20000
`define STIC_TICK_CYCLES (`STIC_TICK_MS * `STIC_CLK_KHZ)

`endif

// >>> design/stic_pkg.sv
package stic_pkg;

  // Divider sequencing
  typedef enum logic [0:0] {
    STIC_DIV_IDLE = 1'b0,
    STIC_DIV_RUN = 1'b1
  } stic_div_state_t;

  // Motor parameter set codes: 1, 2L, 2H, 3
  typedef enum logic [1:0] {
    STIC_MTR_1 = 2'h0,
    STIC_MTR_2L = 2'h1,
    STIC_MTR_2H = 2'h2,
    STIC_MTR_3 = 2'h3
  } stic_motor_t;

endpackage

// >>> design/stic_divider.sv
`timescale 1ns/100ps
`include "stic_defines.svh"

module stic_divider (
  // Clock and control
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Request
  input wire logic start_in,
  input wire logic [`STIC_RES_W-1:0] divisor_in,
  // Answer
  output logic busy_out,
  output logic done_out,
  output logic [`STIC_SCALE_W-1:0] quotient_out
);

  stic_pkg::stic_div_state_t state; // Sequencer state
  logic [`STIC_RES_W-1:0] divisor; // Latched divisor
  logic [`STIC_RES_W-1:0] rem; // Partial remainder, always below divisor
  logic [5:0] steps; // Bits left to resolve
  logic [`STIC_RES_W:0] shifted; // Remainder with next dividend bit
  logic fits; // Divisor fits into shifted remainder
  logic [`STIC_RES_W:0] diff; // Trial subtraction

  assign shifted = {rem, quotient_out[`STIC_SCALE_W-1]};
  assign diff = shifted - {1'b0, divisor};
  assign fits = shifted >= {1'b0, divisor};
  assign busy_out = (state == stic_pkg::STIC_DIV_RUN);

  // Restoring division, one quotient bit per cycle; fraction falls away
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      state <= stic_pkg::STIC_DIV_IDLE;
      divisor <= `STIC_RES_RST;
      rem <= '0;
      steps <= '0;
      done_out <= 1'b0;
      quotient_out <= '0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      // A new start restarts a division already under way
      if (start_in)
      begin
        state <= stic_pkg::STIC_DIV_RUN;
        divisor <= divisor_in;
        rem <= '0;
        steps <= `STIC_DIV_STEPS;
        quotient_out <= `STIC_DIVIDEND;
      end
      else
      begin
        unique case (state)
          stic_pkg::STIC_DIV_IDLE:
          begin
            state <= stic_pkg::STIC_DIV_IDLE;
          end
          stic_pkg::STIC_DIV_RUN:
          begin
            rem <= fits ? diff[`STIC_RES_W-1:0] : shifted[`STIC_RES_W-1:0];
            quotient_out <= {quotient_out[`STIC_SCALE_W-2:0], fits};
            steps <= steps - 6'h01;
            if (steps == 6'h01)
            begin
              state <= stic_pkg::STIC_DIV_IDLE;
              done_out <= 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule // stic_divider

// >>> design/stic_inpos.sv
`timescale 1ns/100ps
`include "stic_defines.svh"

module stic_inpos #(
  parameter int TICK_CYCLES = `STIC_TICK_CYCLES
) (
  // Clock and control
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Loop quantities
  input wire logic signed [31:0] following_error_in,
  input wire logic [`STIC_DBAND_W-1:0] dead_band_in,
  input wire logic [`STIC_INPOS_W-1:0] periods_in,
  // Result
  output logic in_position_out
);

  logic [31:0] tick_cnt; // Cycles within current test interval
  logic [`STIC_INPOS_W-1:0] good_cnt; // Clean intervals in a row
  logic clean; // No excursion seen this interval
  logic [31:0] err_abs; // Magnitude of following error
  logic in_band; // Error within dead band
  logic tick_end; // Last cycle of an interval
  logic [`STIC_INPOS_W-1:0] next_good; // Saturating interval count

  assign err_abs = following_error_in[31] ? 32'(-following_error_in) : following_error_in;
  assign in_band = err_abs <= {4'h0, dead_band_in};
  assign tick_end = (tick_cnt == 32'(TICK_CYCLES - 1));
  assign next_good = (&good_cnt) ? good_cnt : good_cnt + 15'h0001;

  // Interval timer and settle counter
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      tick_cnt <= '0;
      good_cnt <= '0;
      clean <= 1'b1;
      in_position_out <= 1'b0;
    end
    else if (ce_in)
    begin
      tick_cnt <= tick_end ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (!in_band)
      begin
        // Any excursion spoils the interval and drops the output at once
        clean <= 1'b0;
        good_cnt <= '0;
        in_position_out <= 1'b0;
      end
      else if (tick_end)
      begin
        clean <= 1'b1;
        good_cnt <= clean ? next_good : '0;
        in_position_out <= clean && (next_good >= periods_in);
      end
    end
  end

endmodule // stic_inpos

// >>> design/stic_config.sv
// Contract
// - integral gain max 0..32767, default 9000
// - integral gain equals percent times maximum
// - in-position after n clean 10 ms periods
// - period count 1..32767, default two
// - any excursion blocks in-position for interval
// - scale equals 12800*65536/steps, truncated
// - counts equal distance times scale over 65536
// - targets computed from absolute distance each move
// - resolution changes only while amplifier off
// - motor code must match drive power class
// - in band when absolute error within dead band
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "stic_defines.svh"

module stic_config #(
  parameter int TICK_CYCLES = `STIC_TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Register port
  input wire logic [`STIC_ADDR_W-1:0] addr_in,
  input wire logic [`STIC_DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`STIC_DATA_W-1:0] rd_data_out,
  // Drive state
  input wire logic amp_enable_in,
  input wire logic high_power_in,
  input wire logic signed [31:0] following_error_in,
  // Results
  output logic in_position_out,
  output logic [`STIC_IGAIN_W-1:0] integral_gain_out,
  output logic [`STIC_SCALE_W-1:0] scale_factor_out,
  output logic [`STIC_DATA_W-1:0] target_counts_out,
  output logic [`STIC_MOTOR_W-1:0] motor_set_out,
  output logic motor_load_out
);

  // Stored settings
  logic [`STIC_IGMAX_W-1:0] ig_max; // Integral gain maximum
  logic [`STIC_IGPCT_W-1:0] ig_pct; // Integral gain percent
  logic [`STIC_INPOS_W-1:0] inpos_periods; // Settle periods
  logic [`STIC_RES_W-1:0] resolution; // Steps per revolution
  logic [`STIC_DBAND_W-1:0] dead_band; // Dead band in steps
  logic [`STIC_DATA_W-1:0] distance; // Last absolute distance
  logic reject; // Last settings write was refused

  // Divider handshake
  logic div_busy; // Scale being recomputed
  logic div_done; // New scale ready
  logic [`STIC_SCALE_W-1:0] div_quot; // Quotient from divider
  logic inpos; // Detector result

  // Decoded writes
  logic wr_igmax; // Write to integral maximum
  logic wr_igpct; // Write to percent
  logic wr_inpos; // Write to period count
  logic wr_res; // Write to resolution
  logic wr_motor; // Write to motor select
  logic wr_dband; // Write to dead band
  logic wr_dist; // Write to distance
  logic ok_igmax; // Value in range
  logic ok_igpct; // Value in range
  logic ok_inpos; // Value in range
  logic ok_res; // Value in range and amplifier off
  logic ok_motor; // Code fits this drive
  logic ok_dband; // Value in range
  logic any_wr; // A mapped settings write
  logic any_ok; // That write was taken
  logic [`STIC_PROD_W-1:0] product; // Distance times scale
  logic [`STIC_IGAIN_W-1:0] gain_prod; // Percent times maximum
  logic [`STIC_DATA_W-1:0] status_word; // Status register view
  logic [`STIC_DATA_W-1:0] next_rd; // Read mux result
  logic [`STIC_MOTOR_W-1:0] wr_code; // Requested motor code

  // Address match shared by every write decode
  function automatic logic hit(input logic [`STIC_ADDR_W-1:0] a,
                               input logic [`STIC_ADDR_W-1:0] reg_off);
    hit = (a == reg_off);
  endfunction

  // Value sits in a range and nothing above the field is set
  function automatic logic in_range(input logic [`STIC_DATA_W-1:0] v,
                                    input logic [`STIC_DATA_W-1:0] lo,
                                    input logic [`STIC_DATA_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  assign wr_igmax = wr_in && hit(addr_in, `STIC_REG_IGMAX);
  assign wr_igpct = wr_in && hit(addr_in, `STIC_REG_IGPCT);
  assign wr_inpos = wr_in && hit(addr_in, `STIC_REG_INPOS);
  assign wr_res = wr_in && hit(addr_in, `STIC_REG_RES);
  assign wr_motor = wr_in && hit(addr_in, `STIC_REG_MOTOR);
  assign wr_dband = wr_in && hit(addr_in, `STIC_REG_DBAND);
  assign wr_dist = wr_in && hit(addr_in, `STIC_REG_DIST);

  // Range checks; out-of-range values leave the setting alone
  assign ok_igmax = in_range(wr_data_in, '0, {17'h00000, {`STIC_IGMAX_W{1'b1}}});
  assign ok_igpct = in_range(wr_data_in, '0, {25'h0000000, `STIC_IGPCT_MAX});
  assign ok_inpos = in_range(wr_data_in, {17'h00000, `STIC_INPOS_MIN},
                             {17'h00000, {`STIC_INPOS_W{1'b1}}});
  assign ok_res = !amp_enable_in
                  && in_range(wr_data_in, {17'h00000, `STIC_RES_MIN},
                              {17'h00000, `STIC_RES_MAX});
  assign wr_code = wr_data_in[`STIC_MOTOR_W-1:0];
  // Low power takes 1 or 2L, high power 2H or 3
  assign ok_motor = (wr_data_in[`STIC_DATA_W-1:`STIC_MOTOR_W] == '0)
                    && (wr_code[1] == high_power_in);
  assign ok_dband = in_range(wr_data_in, '0, {4'h0, `STIC_DBAND_MAX});

  assign any_wr = wr_igmax || wr_igpct || wr_inpos || wr_res || wr_motor || wr_dband;
  assign any_ok = (wr_igmax && ok_igmax) || (wr_igpct && ok_igpct)
                  || (wr_inpos && ok_inpos) || (wr_res && ok_res)
                  || (wr_motor && ok_motor) || (wr_dband && ok_dband);

  // Integral gain is percent times the maximum, never an absolute value
  assign gain_prod = `STIC_IGAIN_W'(ig_pct * ig_max);

  // Counts from the absolute distance, fraction truncated by the shift
  assign product = {32'h00000000, distance} * {32'h00000000, scale_factor_out};

  assign status_word = {28'h0000000, reject, div_busy, amp_enable_in, inpos};

  // Read view; a bare read reports the stored value unchanged
  assign next_rd =
    hit(addr_in, `STIC_REG_IGMAX) ? {17'h00000, ig_max} :
    hit(addr_in, `STIC_REG_IGPCT) ? {25'h0000000, ig_pct} :
    hit(addr_in, `STIC_REG_INPOS) ? {17'h00000, inpos_periods} :
    hit(addr_in, `STIC_REG_RES) ? {17'h00000, resolution} :
    hit(addr_in, `STIC_REG_MOTOR) ? {30'h00000000, motor_set_out} :
    hit(addr_in, `STIC_REG_DBAND) ? {4'h0, dead_band} :
    hit(addr_in, `STIC_REG_SCALE) ? scale_factor_out :
    hit(addr_in, `STIC_REG_IGAIN) ? {10'h000, integral_gain_out} :
    hit(addr_in, `STIC_REG_DIST) ? distance :
    hit(addr_in, `STIC_REG_TARGET) ? target_counts_out :
    hit(addr_in, `STIC_REG_STATUS) ? status_word :
    32'h00000000;

  // Scale factor recomputed in the background after a resolution change
  stic_divider u_div (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .start_in(wr_res && ok_res),
    .divisor_in(wr_data_in[`STIC_RES_W-1:0]),
    .busy_out(div_busy),
    .done_out(div_done),
    .quotient_out(div_quot)
  );

  // Settle detector on the 10 ms test interval
  stic_inpos #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_inpos (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .following_error_in(following_error_in),
    .dead_band_in(dead_band),
    .periods_in(inpos_periods),
    .in_position_out(inpos)
  );

  // Settings store; each write replaces a value only when valid
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      ig_max <= `STIC_IGMAX_RST;
      ig_pct <= `STIC_IGPCT_RST;
      inpos_periods <= `STIC_INPOS_RST;
      resolution <= `STIC_RES_RST;
      dead_band <= `STIC_DBAND_RST;
      motor_set_out <= `STIC_MOTOR_RST;
      reject <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_igmax && ok_igmax)
      begin
        ig_max <= wr_data_in[`STIC_IGMAX_W-1:0];
      end
      if (wr_igpct && ok_igpct)
      begin
        ig_pct <= wr_data_in[`STIC_IGPCT_W-1:0];
      end
      if (wr_inpos && ok_inpos)
      begin
        inpos_periods <= wr_data_in[`STIC_INPOS_W-1:0];
      end
      // Refused while the amplifier runs: stored value stays
      if (wr_res && ok_res)
      begin
        resolution <= wr_data_in[`STIC_RES_W-1:0];
      end
      if (wr_dband && ok_dband)
      begin
        dead_band <= wr_data_in[`STIC_DBAND_W-1:0];
      end
      if (wr_motor && ok_motor)
      begin
        motor_set_out <= wr_code;
      end
      if (any_wr)
      begin
        reject <= !any_ok;
      end
    end
  end

  // Motor parameter set load strobe
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      motor_load_out <= 1'b0;
    end
    else if (ce_in)
    begin
      motor_load_out <= wr_motor && ok_motor;
    end
  end

  // Scale factor holds the truncated quotient once the divider finishes
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      scale_factor_out <= `STIC_SCALE_RST;
    end
    else if (ce_in && div_done)
    begin
      scale_factor_out <= div_quot;
    end
  end

  // Move target rebuilt from the full distance on every request
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      distance <= '0;
      target_counts_out <= '0;
    end
    else if (ce_in)
    begin
      if (wr_dist)
      begin
        distance <= wr_data_in;
      end
      // Follows distance and scale, so no error is carried over
      target_counts_out <= product[`STIC_FRAC_LSB +: `STIC_DATA_W];
    end
  end

  // Output copies registered so every output comes from a flip-flop
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      integral_gain_out <= '0;
      in_position_out <= 1'b0;
    end
    else if (ce_in)
    begin
      integral_gain_out <= gain_prod;
      in_position_out <= inpos;
    end
  end

  // Read data stand for the one cycle after the strobe only
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_out <= '0;
    end
    else if (ce_in)
    begin
      rd_data_out <= rd_in ? next_rd : 32'h00000000;
    end
  end

endmodule // stic_config

// >>> tb/stic_config_properties.sv
`timescale 1ns/100ps
module stic_config_checker #(
  parameter int TICK_CYCLES = 20
) (
  // Clock and register port
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  // Drive state and results
  input wire logic amp_enable_in,
  input wire logic high_power_in,
  input wire logic signed [31:0] following_error_in,
  input wire logic in_position_out,
  input wire logic [21:0] integral_gain_out,
  input wire logic [31:0] scale_factor_out,
  input wire logic [31:0] target_counts_out,
  input wire logic [1:0] motor_set_out,
  input wire logic motor_load_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Mirrors of accepted settings
  logic [31:0] mx, pc, np, db, rs, ds;
  // Cycles since the last excursion
  logic [31:0] clean;
  // Edges since reset, so history is valid
  logic [1:0] age;
  wire wt = wr_in && ce_in;
  wire [31:0] d = wr_data_in;
  wire [31:0] mag = following_error_in[31] ? 32'(-following_error_in) : following_error_in;
  // Error beyond the band on this edge
  wire oob = ce_in && mag > db;
  wire ok = age == 2'h3;
  // Resolution only taken with the amplifier off
  wire res_ok = wt && addr_in == 4'h3 && !amp_enable_in && d >= 32'hC8 && d <= 32'h6400;
  // Shadow of the register map
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      mx <= 32'h2328;
      pc <= 32'h32;
      np <= 32'h2;
      db <= 32'h0;
      rs <= 32'h1388;
      ds <= 32'h0;
      clean <= 32'h0;
      age <= 2'h0;
    end
    else
    begin
      if (wt && addr_in == 4'h0 && d <= 32'h7FFF)
        mx <= d;
      if (wt && addr_in == 4'h1 && d <= 32'h63)
        pc <= d;
      if (wt && addr_in == 4'h2 && d != 32'h0 && d <= 32'h7FFF)
        np <= d;
      if (wt && addr_in == 4'h5 && d <= 32'hA000000)
        db <= d;
      if (res_ok)
        rs <= d;
      if (wt && addr_in == 4'h8)
        ds <= d;
      clean <= oob ? 32'h0 : clean + 32'h1;
      age <= age + {1'b0, age != 2'h3};
    end
  end
  a_read_idle_zero: assert property (ok && $past(ce_in) && !$past(rd_in && ce_in) |-> rd_data_out == 32'h0)
    else $error("read data not zero outside its slot");
  a_load_one_cycle: assert property (motor_load_out && ce_in && !(wt && addr_in == 4'h4) |=> !motor_load_out)
    else $error("motor load longer than one cycle");
  a_load_class: assert property (ok && motor_load_out |-> $past(wt && addr_in == 4'h4) && motor_set_out[1] == $past(high_power_in))
    else $error("motor set loaded for wrong class or cause");
  a_igain_product: assert property (ok && $past(ce_in) |-> integral_gain_out == $past(22'(mx * pc)))
    else $error("integral gain not percent times maximum");
  a_inpos_drop: assert property (oob |-> ##3 !in_position_out)
    else $error("in-position kept after excursion");
  a_inpos_clean: assert property ($rose(in_position_out) |-> clean + 3 >= np * TICK_CYCLES)
    else $error("in-position rose too early");
  a_scale_quotient: assert property (ok && $changed(scale_factor_out) |-> scale_factor_out == 32'h32000000 / rs)
    else $error("scale factor wrong");
  a_target_trunc: assert property (ok && $past(ce_in) |-> target_counts_out == $past(32'((64'(ds) * 64'(scale_factor_out)) >> 16)))
    else $error("target counts wrong");
  c_motor_load: cover property (motor_load_out);
  c_inpos_rise: cover property ($rose(in_position_out));
  c_scale_new: cover property (ok && $changed(scale_factor_out));
endmodule // stic_config_checker
bind stic_config stic_config_checker #(.TICK_CYCLES(TICK_CYCLES)) u_stic_config_checker (.*);

// >>> tb/stic_plant.sv
`timescale 1ns/100ps
module stic_plant (
  // Clock and shaft set-up
  input wire logic ref_clk_in,
  input wire logic signed [31:0] rest_err_in,
  input wire logic kick_in,
  // Error seen by the drive
  output logic signed [31:0] following_error_out
);
  // Resting error, or a one-cycle knock 100000 steps above it
  always_ff @(posedge ref_clk_in)
  begin
    following_error_out <= kick_in ? rest_err_in + 32'sh186A0 : rest_err_in;
  end
endmodule // stic_plant

// >>> tb/stic_config_tb_top.sv
`timescale 1ns/100ps
module stic_config_tb_top;
  localparam int TICK = 20;
  // Write address and data, then read address and expected word
  typedef struct {
    logic [3:0] wa;
    logic [31:0] wd;
    logic [3:0] ra;
    logic [31:0] ex;
  } stic_row_t;
  stic_row_t rows[12] = '{
    '{4'h0, 32'h3E8, 4'h0, 32'h3E8}, '{4'h1, 32'h2D, 4'h7, 32'hAFC8},
    '{4'h0, 32'h7FFF, 4'h0, 32'h7FFF}, '{4'h0, 32'h8000, 4'h0, 32'h7FFF},
    '{4'h7, 32'h1, 4'h7, 32'h167FD3}, '{4'h1, 32'h64, 4'h1, 32'h2D},
    '{4'h2, 32'h0, 4'h2, 32'h2}, '{4'h2, 32'h7FFF, 4'h2, 32'h7FFF},
    '{4'h5, 32'hA000001, 4'h5, 32'h0}, '{4'h5, 32'h32, 4'h5, 32'h32},
    '{4'hF, 32'h5, 4'hF, 32'h0}, '{4'h6, 32'h1, 4'h6, 32'h28F5C}};
  logic [31:0] defs[8] = '{32'h2328, 32'h32, 32'h2, 32'h1388, 32'h0, 32'h0, 32'h28F5C, 32'h6DDD0};
  // Resolution, scale and target for a 500000 step move
  logic [31:0] rs_v[3] = '{32'h1000, 32'hC9, 32'h6400};
  logic [31:0] sc_v[3] = '{32'h32000, 32'h3FAE7C, 32'h8000};
  logic [31:0] tg_v[3] = '{32'h17D784, 32'h1E5DA15, 32'h3D090};
  // Stimulus
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic amp_enable_in = 1'b0;
  logic high_power_in = 1'b0;
  logic kick = 1'b0;
  logic signed [31:0] rest_err = 32'sh0;
  // Observed
  wire signed [31:0] ferr;
  wire [31:0] rd_data_out, scale_factor_out, target_counts_out;
  wire [21:0] integral_gain_out;
  wire [1:0] motor_set_out;
  wire in_position_out, motor_load_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int j;
  logic [1:0] code = 2'h0;
  initial
  begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  stic_plant u_stic_plant (.ref_clk_in(ref_clk_in), .rest_err_in(rest_err), .kick_in(kick),
    .following_error_out(ferr));
  // Clock enable driven by the bench so the freeze case can pull it low
  stic_config #(.TICK_CYCLES(TICK)) u_stic_config (.*, .following_error_in(ferr));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] dat);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= dat;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 chk(what, exp, rd_data_out);
  endtask
  task automatic reset_dut;
    @(posedge ref_clk_in);
    rst_b_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
  endtask
  // Knock the shaft, then time the return of in-position
  task automatic settle(input int lo, input int hi);
    int t;
    @(posedge ref_clk_in);
    kick <= 1'b1;
    @(posedge ref_clk_in);
    kick <= 1'b0;
    for (t = 0; t < 200 && in_position_out !== 1'b1; t++)
      @(negedge ref_clk_in);
    chk("settle time", 32'h1, 32'(t >= lo && t <= hi));
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    reset_dut();
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      @(posedge ref_clk_in);
      rd(rows[i].ra, rows[i].ex, $sformatf("row %0d", i));
    end
    // Every code on both drive classes
    for (int c = 0; c < 8; c++)
    begin
      @(posedge ref_clk_in);
      high_power_in <= c[2];
      wr(4'h4, 32'(c[1:0]));
      #1 chk("motor load", 32'(c[2] == c[1]), 32'(motor_load_out));
      if (c[2] == c[1])
        code = 2'(c[1:0]);
      rd(4'h4, 32'(code), "motor code");
    end
    // Same move twice lands on the same truncated count
    rest_err <= 32'sh3E8;
    repeat (2)
    begin
      wr(4'h8, 32'h7A120);
      repeat (2) @(posedge ref_clk_in);
      rd(4'h9, 32'h1387FE, "target");
    end
    // Amplifier on: resolution refused
    @(posedge ref_clk_in);
    amp_enable_in <= 1'b1;
    wr(4'h3, 32'h1000);
    rd(4'hA, 32'hA, "status");
    repeat (40) @(posedge ref_clk_in);
    chk("scale locked", 32'h28F5C, scale_factor_out);
    amp_enable_in <= 1'b0;
    // Each new resolution restarts a conversion already running
    foreach (rs_v[i])
    begin
      wr(4'h3, 32'hC8);
      wr(4'h3, rs_v[i]);
      for (j = 0; j < 80 && scale_factor_out !== sc_v[i]; j++)
        @(negedge ref_clk_in);
      chk("scale", sc_v[i], scale_factor_out);
      repeat (2) @(negedge ref_clk_in);
      chk("target", tg_v[i], target_counts_out);
    end
    // Clock enable low: divider, writes and reads all hold still
    wr(4'h3, 32'h1000);
    ce_in <= 1'b0;
    repeat (60) @(posedge ref_clk_in);
    chk("frozen scale", 32'h8000, scale_factor_out);
    wr(4'h0, 32'h1);
    @(posedge ref_clk_in);
    ce_in <= 1'b1;
    rd(4'hA, 32'h4, "busy status");
    for (j = 0; j < 80 && scale_factor_out !== 32'h32000; j++)
      @(negedge ref_clk_in);
    chk("thawed scale", 32'h32000, scale_factor_out);
    rd(4'h0, 32'h7FFF, "frozen write");
    wr(4'h2, 32'h2);
    rest_err <= -32'sh32;
    settle(2 * TICK, 3 * TICK + 5);
    rest_err <= -32'sh33;
    repeat (4 * TICK) @(negedge ref_clk_in);
    chk("out of band", 32'h0, 32'(in_position_out));
    // Short knocks inside every interval hold the output off
    rest_err <= -32'sh32;
    repeat (8)
    begin
      repeat (TICK / 2 - 1) @(posedge ref_clk_in);
      kick <= 1'b1;
      @(posedge ref_clk_in);
      kick <= 1'b0;
      #1 chk("knocked", 32'h0, 32'(in_position_out));
    end
    wr(4'h2, 32'h1);
    settle(TICK, 2 * TICK + 5);
    reset_dut();
    @(posedge ref_clk_in);
    foreach (defs[i])
      rd(4'(i), defs[i], $sformatf("default %0d", i));
    chk("motor after reset", 32'h0, 32'(motor_set_out));
    close_out();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    close_out();
  end
endmodule // stic_config_tb_top
